// ===== inc/hpp_pkg.sv
package hpp_pkg;
	// ==========================================
	// Bus and register map
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int BANK_W = 6;
	localparam int PORT_N = 3;
	localparam int PLAIN_N = 4;
	localparam logic [3:0] IDX_POLICY = 4'h2;
	localparam logic [3:0] IDX_VID = 4'h4;
	localparam logic [3:0] IDX_CTRL3 = 4'h6;
	localparam logic [3:0] IDX_IRATE = 4'h8;
	localparam logic [3:0] IDX_ERATE = 4'hA;
	localparam logic [3:0] IDX_BANK = 4'hE;
	localparam logic [3:0] IDX_STRIDE = 4'h2;
	localparam logic [5:0] HOST_BANK = 6'h34;
	localparam logic [5:0] BANK_RST = 6'h00;
	// ==========================================
	// Policy control fields
	localparam int BIT_VFILT = 14;
	localparam int BIT_NOPVID = 13;
	localparam int BIT_TXEN = 10;
	localparam int BIT_RXEN = 9;
	localparam int BIT_LRNDIS = 8;
	localparam int BIT_SNIFFER = 7;
	localparam int BIT_RXSNIFF = 6;
	localparam int BIT_TXSNIFF = 5;
	localparam int BIT_PCEIL = 3;
	localparam int MEMB_LSB = 0;
	localparam int HOST_BIT = 2;
	localparam logic [15:0] POLICY_RST = 16'h0607;
	localparam logic [15:0] POLICY_MASK = 16'h67EF;
	localparam logic [15:0] PLAIN_RST = 16'h0000;
	localparam logic [2:0] MEMB_ALL = 3'h7;
	// ==========================================
	// Default tag layout
	localparam int VID_W = 12;
	localparam int PRIO_W = 3;
	localparam int VID_LSB = 0;
	localparam int PRIO_LSB = 13;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic vfilt;
		logic nopvid;
		logic txen;
		logic rxen;
		logic lrndis;
		logic sniffer;
		logic rxsniff;
		logic txsniff;
		logic pceil;
		logic [PORT_N-1:0] memb;
		logic [VID_W-1:0] port_default_vlan_id;
		logic [PRIO_W-1:0] dprio;
	} hpp_pol_s;
	typedef struct packed {
		logic valid;
		logic [VID_W-1:0] vid;
		logic [PORT_N-1:0] members;
		logic [PORT_N-1:0] dst;
		logic [PRIO_W-1:0] prio;
	} hpp_ing_s;
	typedef struct packed {
		logic valid;
		logic drop;
		logic learn;
		logic monitored;
		logic [PORT_N-1:0] fwd;
		logic [PRIO_W-1:0] prio;
	} hpp_dec_s;
	typedef struct packed {
		logic valid;
		logic mirror_copy;
	} hpp_egr_s;
endpackage : hpp_pkg

// ===== hw/hpp_ingress.sv
`timescale 1ns/1ps
module hpp_ingress (
	// Policy
	input wire hpp_pkg::hpp_pol_s pol,
	// Frame arriving on the host port
	input wire hpp_pkg::hpp_ing_s ing,
	// Decision
	output hpp_pkg::hpp_dec_s dec
);
	logic vlan_fail;
	logic port_default_vlan_id_fail;

	assign vlan_fail = pol.vfilt && !ing.members[hpp_pkg::HOST_BIT];
	assign port_default_vlan_id_fail = pol.nopvid && (ing.vid != pol.port_default_vlan_id);

	always_comb begin
		dec.valid = ing.valid;
		dec.drop = !pol.rxen || vlan_fail || port_default_vlan_id_fail;
		// Only accepted frames teach the address table
		dec.learn = ing.valid && !dec.drop && !pol.lrndis;
		dec.monitored = ing.valid && !dec.drop && pol.rxsniff;
		dec.fwd = '0;
		if (ing.valid && !dec.drop) begin
			// Never loop back to the ingress port itself
			dec.fwd = ing.dst & pol.memb;
			dec.fwd[hpp_pkg::HOST_BIT] = 1'b0;
		end
		dec.prio = ing.prio;
		if (pol.pceil && (ing.prio > pol.dprio)) begin
			dec.prio = pol.dprio;
		end
	end
endmodule : hpp_ingress

// ===== hw/hpp_egress.sv
`timescale 1ns/1ps
module hpp_egress (
	// Policy
	input wire hpp_pkg::hpp_pol_s pol,
	// Frame offered for transmit
	input wire hpp_pkg::hpp_egr_s egr,
	// Results
	output logic tx_go,
	output logic tx_mirror
);
	logic allowed;

	// Mirror copies only leave through the designated sniffer port
	assign allowed = !egr.mirror_copy || pol.sniffer;
	assign tx_go = egr.valid && pol.txen && allowed;
	assign tx_mirror = tx_go && !egr.mirror_copy && pol.txsniff;
endmodule : hpp_egress

// ===== hw/hpp_host_port_policy.sv
`timescale 1ns/1ps
module hpp_host_port_policy (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [hpp_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [hpp_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [hpp_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Ingress frame decision
	input wire hpp_pkg::hpp_ing_s ing_in,
	output hpp_pkg::hpp_dec_s dec_out,
	// Egress frame gate
	input wire hpp_pkg::hpp_egr_s egr_in,
	output logic tx_go,
	output logic tx_mirror,
	// Live policy view
	output hpp_pkg::hpp_pol_s pol_out
);
	// ==========================================
	// Register storage
	logic [hpp_pkg::REG_W-1:0] pol_q;
	logic [hpp_pkg::REG_W-1:0] plain_q [hpp_pkg::PLAIN_N];
	logic [hpp_pkg::BANK_W-1:0] bank_q;
	logic [hpp_pkg::DATA_W-1:0] rdata_q;
	logic [hpp_pkg::DATA_W-1:0] rdata_d;
	logic wait_q;
	logic req;
	logic commit;
	logic host_bank;
	logic [hpp_pkg::REG_W-1:0] wmerge;
	hpp_pkg::hpp_pol_s pol;
	hpp_pkg::hpp_dec_s dec_d;
	hpp_pkg::hpp_dec_s dec_q;
	logic tx_go_d;
	logic tx_mirror_d;
	logic tx_go_q;
	logic tx_mirror_q;
	hpp_pkg::hpp_pol_s pol_q2;

	assign req = avs_read || avs_write;
	// Access lands on the edge where waitrequest is seen low
	assign commit = avs_write && !wait_q;
	// Reserved banks map nothing but bank select
	assign host_bank = (bank_q == hpp_pkg::HOST_BANK);

	always_comb begin
		wmerge[7:0] = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
		wmerge[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : 8'h00;
	end

	// ==========================================
	// Bus handshake
	// One wait cycle per access, so every request is answered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(req && wait_q);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (avs_read && wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// Register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bank_q <= hpp_pkg::BANK_RST;
		end else if (commit && avs_address == hpp_pkg::IDX_BANK && avs_byteenable[0]) begin
			bank_q <= avs_writedata[hpp_pkg::BANK_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pol_q <= hpp_pkg::POLICY_RST;
		end else if (commit && host_bank && avs_address == hpp_pkg::IDX_POLICY) begin
			for (int b = 0; b < hpp_pkg::REG_W; b++) begin
				if (avs_byteenable[b / 8]) begin
					// Reserved bits never store
					pol_q[b] <= wmerge[b] & hpp_pkg::POLICY_MASK[b];
				end
			end
		end
	end

	genvar k;
	generate
		for (k = 0; k < hpp_pkg::PLAIN_N; k++) begin : g_plain
			localparam logic [3:0] IDX = 4'(hpp_pkg::IDX_VID + k * hpp_pkg::IDX_STRIDE);
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					plain_q[k] <= hpp_pkg::PLAIN_RST;
				end else if (commit && host_bank && avs_address == IDX) begin
					if (avs_byteenable[0]) begin
						plain_q[k][7:0] <= wmerge[7:0];
					end
					if (avs_byteenable[1]) begin
						plain_q[k][15:8] <= wmerge[15:8];
					end
				end
			end
		end
	endgenerate

	// ==========================================
	// Read mux
	always_comb begin
		rdata_d = '0;
		if (avs_address == hpp_pkg::IDX_BANK) begin
			rdata_d[hpp_pkg::BANK_W-1:0] = bank_q;
		end else if (host_bank) begin
			unique case (avs_address)
				hpp_pkg::IDX_POLICY: rdata_d[15:0] = pol_q & hpp_pkg::POLICY_MASK;
				hpp_pkg::IDX_VID: rdata_d[15:0] = plain_q[0];
				hpp_pkg::IDX_CTRL3: rdata_d[15:0] = plain_q[1];
				hpp_pkg::IDX_IRATE: rdata_d[15:0] = plain_q[2];
				hpp_pkg::IDX_ERATE: rdata_d[15:0] = plain_q[3];
				default: rdata_d = '0;
			endcase
		end
	end

	// ==========================================
	// Policy decode
	always_comb begin
		pol.vfilt = pol_q[hpp_pkg::BIT_VFILT];
		pol.nopvid = pol_q[hpp_pkg::BIT_NOPVID];
		pol.txen = pol_q[hpp_pkg::BIT_TXEN];
		pol.rxen = pol_q[hpp_pkg::BIT_RXEN];
		pol.lrndis = pol_q[hpp_pkg::BIT_LRNDIS];
		pol.sniffer = pol_q[hpp_pkg::BIT_SNIFFER];
		pol.rxsniff = pol_q[hpp_pkg::BIT_RXSNIFF];
		pol.txsniff = pol_q[hpp_pkg::BIT_TXSNIFF];
		pol.pceil = pol_q[hpp_pkg::BIT_PCEIL];
		pol.memb = pol_q[hpp_pkg::MEMB_LSB +: hpp_pkg::PORT_N];
		pol.port_default_vlan_id = plain_q[0][hpp_pkg::VID_LSB +: hpp_pkg::VID_W];
		pol.dprio = plain_q[0][hpp_pkg::PRIO_LSB +: hpp_pkg::PRIO_W];
	end

	hpp_ingress u_ingress (
		.pol(pol),
		.ing(ing_in),
		.dec(dec_d)
	);

	hpp_egress u_egress (
		.pol(pol),
		.egr(egr_in),
		.tx_go(tx_go_d),
		.tx_mirror(tx_mirror_d)
	);

	// ==========================================
	// Output registers
	// One cycle of latency keeps every output straight off a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_go_q <= 1'b0;
			tx_mirror_q <= 1'b0;
		end else begin
			tx_go_q <= tx_go_d;
			tx_mirror_q <= tx_mirror_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pol_q2 <= '0;
		end else begin
			pol_q2 <= pol;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign dec_out = dec_q;
	assign tx_go = tx_go_q;
	assign tx_mirror = tx_mirror_q;
	assign pol_out = pol_q2;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_req_seen;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	property p_bus_answer;
		s_req_seen |=> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

	property p_vlan_filter;
		ing_in.valid && pol.vfilt && !ing_in.members[hpp_pkg::HOST_BIT] |=> dec_out.drop;
	endproperty
	a_vlan_filter: assert property (p_vlan_filter) else $error("vlan filter miss");

	property p_port_default_vlan_id;
		ing_in.valid && pol.nopvid && ing_in.vid != pol.port_default_vlan_id |=> dec_out.drop && !dec_out.learn;
	endproperty
	a_port_default_vlan_id: assert property (p_port_default_vlan_id) else $error("non default vid kept");

	property p_tx_block;
		!pol.txen |=> !tx_go && !tx_mirror;
	endproperty
	a_tx_block: assert property (p_tx_block) else $error("tx while disabled");

	property p_rx_block;
		ing_in.valid && !pol.rxen |=> dec_out.drop && dec_out.fwd == '0;
	endproperty
	a_rx_block: assert property (p_rx_block) else $error("rx while disabled");

	property p_learn;
		ing_in.valid |=> dec_out.learn == (!dec_out.drop && !$past(pol.lrndis));
	endproperty
	a_learn: assert property (p_learn) else $error("learn control wrong");

	property p_sniffer;
		egr_in.valid && egr_in.mirror_copy && pol.txen |=> tx_go == $past(pol.sniffer);
	endproperty
	a_sniffer: assert property (p_sniffer) else $error("monitored copy gate wrong");

	property p_rx_sniff;
		ing_in.valid && pol.rxsniff && pol.rxen && !pol.vfilt && !pol.nopvid |=> dec_out.monitored;
	endproperty
	a_rx_sniff: assert property (p_rx_sniff) else $error("rx frame not monitored");

	property p_tx_sniff;
		egr_in.valid && !egr_in.mirror_copy && pol.txen && pol.txsniff |=> tx_mirror && tx_go;
	endproperty
	a_tx_sniff: assert property (p_tx_sniff) else $error("tx frame not mirrored");

	property p_ceiling;
		ing_in.valid |=> dec_out.prio == (($past(pol.pceil) && $past(ing_in.prio) > $past(pol.dprio))
			? $past(pol.dprio) : $past(ing_in.prio));
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("priority ceiling wrong");

	property p_memb_reset;
		$fell(sys_rst) |-> pol.memb == hpp_pkg::MEMB_ALL && pol.txen && pol.rxen;
	endproperty
	a_memb_reset: assert property (p_memb_reset) else $error("policy reset value wrong");

	property p_fwd_mask;
		ing_in.valid |=> (dec_out.fwd & ~$past(pol.memb)) == '0;
	endproperty
	a_fwd_mask: assert property (p_fwd_mask) else $error("forward outside membership");

	property p_reserved;
		avs_read && !avs_waitrequest |-> (avs_readdata[31:16] == '0)
			&& (avs_address != hpp_pkg::IDX_POLICY
			|| (avs_readdata[15:0] & ~hpp_pkg::POLICY_MASK) == '0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("upper read bits not zero");

	property p_rsvd_bank;
		avs_read && avs_waitrequest && !host_bank && avs_address != hpp_pkg::IDX_BANK
			|=> avs_readdata == '0;
	endproperty
	a_rsvd_bank: assert property (p_rsvd_bank) else $error("reserved bank not empty");

	// Ignored writes must leave every host register untouched
	property p_rsvd_write;
		commit && !host_bank && avs_address != hpp_pkg::IDX_BANK
			|=> $stable(pol_q) && $stable(plain_q[0]) && $stable(plain_q[1])
			&& $stable(plain_q[2]) && $stable(plain_q[3]);
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved bank write stored");

	property p_bank_write;
		commit && avs_address == hpp_pkg::IDX_BANK && avs_byteenable[0]
			|=> bank_q == $past(avs_writedata[hpp_pkg::BANK_W-1:0]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select not stored");

	property p_policy_write;
		commit && host_bank && avs_address == hpp_pkg::IDX_POLICY && avs_byteenable[1:0] == 2'h3
			|=> pol_q == ($past(avs_writedata[hpp_pkg::REG_W-1:0]) & hpp_pkg::POLICY_MASK);
	endproperty
	a_policy_write: assert property (p_policy_write) else $error("policy write wrong");

	property p_wait_idle;
		!req && avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
endmodule : hpp_host_port_policy

// ===== tb/hpp_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host software as an Avalon-MM master
module hpp_host_model (
	// Clock
	input wire logic clk,
	// Avalon-MM master side
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		// Released lines must not keep the old value
		avs_address <= ~a;
		avs_writedata <= ~{16'h0000, d};
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_byteenable <= 4'hF;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_address <= ~a;
	endtask : rd
endmodule : hpp_host_model

// ===== tb/tb_hpp_host_port_policy.sv
`timescale 1ns/1ps
module tb_hpp_host_port_policy;
	logic clk;
	logic sys_rst;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	hpp_pkg::hpp_ing_s ing_in;
	hpp_pkg::hpp_dec_s dec_out;
	hpp_pkg::hpp_egr_s egr_in;
	hpp_pkg::hpp_pol_s pol_out;
	logic tx_go;
	logic tx_mirror;
	int errors;
	int num_checks;
	int cyc;
	logic [15:0] r;
	logic [15:0] p;
	logic [15:0] pols [6] = '{16'hFFFF, 16'h4603, 16'h2707, 16'h06EE, 16'h0000, 16'h0405};

	hpp_host_model i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	hpp_host_port_policy i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ing_in(ing_in), .dec_out(dec_out),
		.egr_in(egr_in), .tx_go(tx_go), .tx_mirror(tx_mirror), .pol_out(pol_out));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================
	// Timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		i_host.rd(a, r);
		chk(r, exp);
	endtask : rchk

	// ==========================================
	// Expected decision from policy word p and default tag v
	function automatic logic [15:0] exp_dec(input logic [15:0] p, input logic [15:0] v,
		input logic [11:0] vid, input logic [2:0] mem, input logic [2:0] dst,
		input logic [2:0] pr);
		logic d;
		logic [2:0] q;
		d = !p[9] | (p[14] & !mem[2]) | (p[13] & (vid != v[11:0]));
		q = (p[3] && pr > v[15:13]) ? v[15:13] : pr;
		return {6'h00, 1'b1, d, !d & !p[8], !d & p[6], d ? 3'b000 : dst & p[2:0] & 3'b011, q};
	endfunction : exp_dec

	// Policy word as the flag and membership fields of the live view
	function automatic logic [15:0] pol_view(input logic [15:0] w);
		return {4'h0, w[14], w[13], w[10:5], w[3], w[2:0]};
	endfunction : pol_view

	task automatic frame(input logic [11:0] vid, input logic [2:0] mem, input logic [2:0] pr,
		input logic mc);
		@(posedge clk);
		ing_in <= '{1'b1, vid, mem, 3'b111, pr};
		egr_in <= '{1'b1, mc};
		@(posedge clk);
		ing_in <= '0;
		egr_in <= '0;
		@(negedge clk);
		chk({6'h00, dec_out}, exp_dec(p, 16'hA005, vid, mem, 3'b111, pr));
		chk({14'h0, tx_go, tx_mirror}, {14'h0, p[10] & (!mc | p[7]),
			p[10] & (!mc | p[7]) & !mc & p[5]});
	endtask : frame

	initial begin
		errors = 0;
		num_checks = 0;
		cyc = 0;
		sys_rst = 1'b1;
		ing_in = '0;
		egr_in = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(hpp_pkg::IDX_POLICY, 16'h0000);
		rchk(hpp_pkg::IDX_BANK, 16'h0000);
		i_host.wr(hpp_pkg::IDX_BANK, 16'h0034, 4'hF);
		rchk(hpp_pkg::IDX_POLICY, 16'h0607);
		rchk(hpp_pkg::IDX_CTRL3, 16'h0000);
		i_host.wr(hpp_pkg::IDX_CTRL3, 16'hFFFF, 4'h1);
		rchk(hpp_pkg::IDX_CTRL3, 16'h00FF);
		i_host.wr(hpp_pkg::IDX_CTRL3, 16'h1200, 4'h2);
		rchk(hpp_pkg::IDX_CTRL3, 16'h12FF);
		i_host.wr(hpp_pkg::IDX_IRATE, 16'hC3A5, 4'hF);
		i_host.wr(hpp_pkg::IDX_ERATE, 16'h5A3C, 4'hF);
		i_host.wr(hpp_pkg::IDX_VID, 16'hA005, 4'hF);
		rchk(hpp_pkg::IDX_IRATE, 16'hC3A5);
		rchk(hpp_pkg::IDX_ERATE, 16'h5A3C);
		rchk(hpp_pkg::IDX_VID, 16'hA005);
		rchk(4'hC, 16'h0000);
		// Reserved bank keeps only the bank select reachable
		i_host.wr(hpp_pkg::IDX_BANK, 16'h0035, 4'hF);
		rchk(hpp_pkg::IDX_BANK, 16'h0035);
		rchk(hpp_pkg::IDX_POLICY, 16'h0000);
		i_host.wr(hpp_pkg::IDX_VID, 16'h1111, 4'hF);
		i_host.wr(hpp_pkg::IDX_BANK, 16'h0034, 4'hF);
		rchk(hpp_pkg::IDX_VID, 16'hA005);
		for (int k = 0; k < 6; k++) begin
			i_host.wr(hpp_pkg::IDX_POLICY, pols[k], 4'hF);
			p = pols[k] & hpp_pkg::POLICY_MASK;
			rchk(hpp_pkg::IDX_POLICY, p);
			// Live view: flag and membership fields, then default tag
			chk({4'h0, pol_out[26:15]}, pol_view(p));
			chk({1'b0, pol_out.dprio, pol_out.port_default_vlan_id}, 16'h5005);
			for (int i = 0; i < 4; i++) begin
				frame(i[0] ? 12'h005 : 12'h123, i[1] ? 3'b011 : 3'b100, i[0] ? 3'h7 : 3'h2,
					i[1] ^ i[0]);
			end
		end
		// Reset in mid-run brings bank select, policy and default tag back to their defaults
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(hpp_pkg::IDX_BANK, 16'h0000);
		i_host.wr(hpp_pkg::IDX_BANK, 16'h0034, 4'hF);
		rchk(hpp_pkg::IDX_POLICY, 16'h0607);
		rchk(hpp_pkg::IDX_VID, 16'h0000);
		chk({4'h0, pol_out[26:15]}, pol_view(16'h0607));
		report_and_stop();
	end
endmodule : tb_hpp_host_port_policy
